// *** ddio_pkg.sv ***
// Package for the debounced digital I/O port: widths, timing and resets.
// Assumes nothing beyond a SystemVerilog compiler.
package ddio_pkg;
    localparam int DDIO_CHANNELS = 16;
    localparam int DDIO_PORT_W = 8;
    localparam int DDIO_FSET_W = 5;
    localparam logic [4:0] DDIO_FSET_MAX = 5'h14;
    localparam logic [4:0] DDIO_FSET_RST = 5'h00;
    localparam logic [15:0] DDIO_OUT_RST = 16'h0000;
    localparam logic [15:0] DDIO_IN_RST = 16'h0000;
    // Idle level of the active-low pins, loaded into the synchroniser.
    localparam logic [15:0] DDIO_PIN_RST = 16'hFFFF;
    // Filter base clock and core clock, in kHz.
    localparam int DDIO_BASE_KHZ = 8000;
    localparam int DDIO_CORE_KHZ = 50000;
    // Filter time unit is 2**n base periods; base period in ps is 125000.
    localparam int DDIO_BASE_PS = 1000000000 / DDIO_BASE_KHZ;
    localparam int DDIO_CORE_PS = 1000000000 / DDIO_CORE_KHZ;
    // Core cycles for 2**n base periods, scaled by 2**n before dividing; least time
    // rounds up, so the count per base period is kept as a ratio.
    localparam int DDIO_CNT_W = 28;
endpackage : ddio_pkg

// *** ddio_port.sv ***
// Debounced 16-in, 16-out digital I/O port with output readback.
// Assumes input pins are asynchronous; host side shares core_clk.
`timescale 1ns/1ps
`default_nettype none
module ddio_port
    import ddio_pkg::*;
#(
    parameter int CORE_KHZ = DDIO_CORE_KHZ,
    parameter int BASE_KHZ = DDIO_BASE_KHZ
) (
    // Clock, reset and clock enable.
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // Connector pins.
    input wire logic [7:0] io_connector_in0_n,
    input wire logic [7:0] io_connector_in1_n,
    output logic [7:0] io_connector_out0,
    output logic [7:0] io_connector_out1,
    // Host output write and readback.
    input wire logic out0_we,
    input wire logic [7:0] out0_wdata,
    input wire logic out1_we,
    input wire logic [7:0] out1_wdata,
    output logic [7:0] out0_rdata,
    output logic [7:0] out1_rdata,
    // Host filter setting.
    input wire logic fset_we,
    input wire logic [4:0] fset_wdata,
    output logic [4:0] fset_rdata,
    // Host input data.
    output logic [7:0] in0_rdata,
    output logic [7:0] in1_rdata
);
    // ------------------------------------------------------------
    // Filter time arithmetic
    // ------------------------------------------------------------
    // Core cycles for 2**n base periods, rounded up, at least one.
    function automatic logic [DDIO_CNT_W-1:0] ddio_cycles(
        input logic [4:0] n);
        longint num;
        longint cyc;
        num = longint'(CORE_KHZ) << n;
        cyc = (num + longint'(BASE_KHZ) - 1) / longint'(BASE_KHZ);
        if (cyc < 1) begin
            cyc = 1;
        end
        ddio_cycles = DDIO_CNT_W'(cyc);
    endfunction : ddio_cycles

    // ------------------------------------------------------------
    // Filter decision
    // ------------------------------------------------------------
    // Next filtered level of one channel; bypass copies the sample.
    function automatic logic ddio_filt_bit(
        input logic byp,
        input logic samp_b,
        input logic filt_b,
        input logic [DDIO_CNT_W-1:0] cnt,
        input logic [DDIO_CNT_W-1:0] lim);
        logic nxt;
        nxt = filt_b;
        if (byp) begin
            nxt = samp_b;
        end else if (samp_b != filt_b && cnt + 1'b1 >= lim) begin
            nxt = samp_b;
        end
        ddio_filt_bit = nxt;
    endfunction : ddio_filt_bit

    // Next stability count of one channel; a match restarts it.
    function automatic logic [DDIO_CNT_W-1:0] ddio_filt_cnt(
        input logic byp,
        input logic samp_b,
        input logic filt_b,
        input logic [DDIO_CNT_W-1:0] cnt,
        input logic [DDIO_CNT_W-1:0] lim);
        logic [DDIO_CNT_W-1:0] nxt;
        nxt = '0;
        if (!byp && samp_b != filt_b && cnt + 1'b1 < lim) begin
            nxt = cnt + 1'b1;
        end
        ddio_filt_cnt = nxt;
    endfunction : ddio_filt_cnt

    // ------------------------------------------------------------
    // Output latches
    // ------------------------------------------------------------
    // Port 0 latch holds channels 0 to 7.
    logic [7:0] out0_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out0_r <= DDIO_OUT_RST[7:0];
        end else if (clk_en && out0_we) begin
            out0_r <= out0_wdata;
        end
    end

    // Port 1 latch holds channels 8 to 15.
    logic [7:0] out1_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out1_r <= DDIO_OUT_RST[15:8];
        end else if (clk_en && out1_we) begin
            out1_r <= out1_wdata;
        end
    end

    // ------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------
    // Port 0 pins mirror the latch; one turns the transistor on.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            io_connector_out0 <= DDIO_OUT_RST[7:0];
        end else if (clk_en) begin
            io_connector_out0 <= out0_r;
        end
    end

    // Port 1 pins mirror the latch; one turns the transistor on.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            io_connector_out1 <= DDIO_OUT_RST[15:8];
        end else if (clk_en) begin
            io_connector_out1 <= out1_r;
        end
    end

    // ------------------------------------------------------------
    // Output readback
    // ------------------------------------------------------------
    // Port 0 readback copies the latch; reading changes nothing.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out0_rdata <= DDIO_OUT_RST[7:0];
        end else if (clk_en) begin
            out0_rdata <= out0_r;
        end
    end

    // Port 1 readback copies the latch; reading changes nothing.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            out1_rdata <= DDIO_OUT_RST[15:8];
        end else if (clk_en) begin
            out1_rdata <= out1_r;
        end
    end

    // ------------------------------------------------------------
    // Filter setting
    // ------------------------------------------------------------
    logic [4:0] fset_r;
    logic [DDIO_CNT_W-1:0] limit_r;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fset_r <= DDIO_FSET_RST;
        end else if (clk_en && fset_we && fset_wdata <= DDIO_FSET_MAX) begin
            fset_r <= fset_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            limit_r <= ddio_cycles(DDIO_FSET_RST);
        end else if (clk_en) begin
            limit_r <= ddio_cycles(fset_r);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fset_rdata <= DDIO_FSET_RST;
        end else if (clk_en) begin
            fset_rdata <= fset_r;
        end
    end

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    logic [7:0] meta0_r;
    logic [7:0] meta1_r;
    logic [7:0] sync0_r;
    logic [7:0] sync1_r;
    // Port 0 pins pass two flip-flops; only the second is read.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta0_r <= DDIO_PIN_RST[7:0];
            sync0_r <= DDIO_PIN_RST[7:0];
        end else if (clk_en) begin
            meta0_r <= io_connector_in0_n;
            sync0_r <= meta0_r;
        end
    end

    // Port 1 pins pass two flip-flops; only the second is read.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta1_r <= DDIO_PIN_RST[15:8];
            sync1_r <= DDIO_PIN_RST[15:8];
        end else if (clk_en) begin
            meta1_r <= io_connector_in1_n;
            sync1_r <= meta1_r;
        end
    end

    logic [15:0] samp;
    assign samp = ~{sync1_r, sync0_r};

    // ------------------------------------------------------------
    // Per-channel debounce
    // ------------------------------------------------------------
    logic byp;
    assign byp = (fset_r == DDIO_FSET_RST);
    logic [7:0] filt0_r;
    logic [7:0] filt1_r;
    logic [DDIO_CNT_W-1:0] cnt0_r [DDIO_PORT_W];
    logic [DDIO_CNT_W-1:0] cnt1_r [DDIO_PORT_W];

    // Port 0 filtered levels.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            filt0_r <= DDIO_IN_RST[7:0];
        end else if (clk_en) begin
            for (int i = 0; i < DDIO_PORT_W; i++) begin
                filt0_r[i] <= ddio_filt_bit(byp, samp[i], filt0_r[i],
                    cnt0_r[i], limit_r);
            end
        end
    end

    // Port 0 stability counters.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < DDIO_PORT_W; i++) begin
                cnt0_r[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < DDIO_PORT_W; i++) begin
                cnt0_r[i] <= ddio_filt_cnt(byp, samp[i], filt0_r[i],
                    cnt0_r[i], limit_r);
            end
        end
    end

    // Port 1 filtered levels.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            filt1_r <= DDIO_IN_RST[15:8];
        end else if (clk_en) begin
            for (int i = 0; i < DDIO_PORT_W; i++) begin
                filt1_r[i] <= ddio_filt_bit(byp, samp[i + DDIO_PORT_W],
                    filt1_r[i], cnt1_r[i], limit_r);
            end
        end
    end

    // Port 1 stability counters.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < DDIO_PORT_W; i++) begin
                cnt1_r[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < DDIO_PORT_W; i++) begin
                cnt1_r[i] <= ddio_filt_cnt(byp, samp[i + DDIO_PORT_W],
                    filt1_r[i], cnt1_r[i], limit_r);
            end
        end
    end

    // ------------------------------------------------------------
    // Input data
    // ------------------------------------------------------------
    // Port 0 input data shows channels 0 to 7.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            in0_rdata <= DDIO_IN_RST[7:0];
        end else if (clk_en) begin
            in0_rdata <= filt0_r;
        end
    end

    // Port 1 input data shows channels 8 to 15.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            in1_rdata <= DDIO_IN_RST[15:8];
        end else if (clk_en) begin
            in1_rdata <= filt1_r;
        end
    end
endmodule : ddio_port
`default_nettype wire

// *** ddio_sw.sv ***
// Switch bank model on the input pins, with board pull-ups.
// Assumes the bench gives switch states; a closed switch pulls low.
`timescale 1ns/1ps
`default_nettype none
module ddio_sw (
    input wire logic [15:0] sw_on,
    output logic [7:0] io_connector_in0_n,
    output logic [7:0] io_connector_in1_n
);
    assign io_connector_in0_n = ~sw_on[7:0];
    assign io_connector_in1_n = ~sw_on[15:8];
endmodule : ddio_sw
`default_nettype wire

// *** ddio_chk_asserts.sv ***
// Checker on the ddio_port ports, bound to every instance.
// Assumes writes keep clk_en high for the two cycles after.
`timescale 1ns/1ps
`default_nettype none
module ddio_chk import ddio_pkg::*; (
    input wire logic core_clk, reset, clk_en, out0_we, out1_we, fset_we,
    input wire logic [7:0] io_connector_in0_n, io_connector_in1_n,
    input wire logic [7:0] io_connector_out0, io_connector_out1,
    input wire logic [7:0] out0_wdata, out1_wdata, out0_rdata, out1_rdata,
    input wire logic [7:0] in0_rdata, in1_rdata,
    input wire logic [4:0] fset_wdata, fset_rdata
);
    wire logic [15:0] pin_n = {io_connector_in1_n, io_connector_in0_n};
    wire logic [15:0] in_r = {in1_rdata, in0_rdata};
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    out0_write_a: assert property (clk_en && out0_we |-> ##2
        io_connector_out0 == $past(out0_wdata, 2)) else $error("out0 pins");
    out1_write_a: assert property (clk_en && out1_we |-> ##2
        io_connector_out1 == $past(out1_wdata, 2)) else $error("out1 pins");
    out_readback_a: assert property (out0_rdata == io_connector_out0
        && out1_rdata == io_connector_out1) else $error("readback");
    out_reset_a: assert property (disable iff (1'b0) reset[*3] |->
        {io_connector_out1, io_connector_out0} == 16'h0000)
        else $error("outputs after reset");
    fset_reset_a: assert property (disable iff (1'b0) reset[*3] |->
        fset_rdata == 5'h00) else $error("filter setting after reset");
    fset_write_a: assert property (clk_en && fset_we &&
        fset_wdata <= DDIO_FSET_MAX |-> ##2 fset_rdata == $past(fset_wdata, 2))
        else $error("filter setting write");
    fset_refuse_a: assert property (clk_en && fset_we &&
        fset_wdata > DDIO_FSET_MAX ##1 !fset_we |=> $stable(fset_rdata))
        else $error("filter setting refuse");
    state_freeze_a: assert property (!clk_en |=> $stable(in_r) &&
        $stable(io_connector_out0)) else $error("freeze");
    filter_bypass_a: assert property (
        (fset_rdata == 5'h00 && $stable(pin_n))[*6] |-> in_r == ~pin_n)
        else $error("bypass input");
    cover property (clk_en && out0_we && out1_we);
    cover property (fset_we && fset_wdata > DDIO_FSET_MAX);
    cover property ($rose(in_r[15]));
endmodule : ddio_chk
`default_nettype wire
bind ddio_port ddio_chk i_ddio_chk (.*);

// *** tb.sv ***
// Testbench for ddio_port with the switch bank model.
// Assumes BASE_KHZ set to CORE_KHZ, so setting n filters 2**n cycles.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic out0_we = 1'b0, out1_we = 1'b0, fset_we = 1'b0;
    logic [7:0] out0_wdata = 8'h00, out1_wdata = 8'h00;
    logic [4:0] fset_wdata = 5'h00;
    logic [15:0] sw_on = 16'h0000;
    wire logic [7:0] io_connector_in0_n, io_connector_in1_n, in0_rdata;
    wire logic [7:0] io_connector_out0, io_connector_out1, in1_rdata;
    wire logic [7:0] out0_rdata, out1_rdata;
    wire logic [4:0] fset_rdata;
    int n_errors = 0, n_checks = 0;
    initial forever #10 core_clk = ~core_clk;
    ddio_sw i_ddio_sw (.sw_on, .io_connector_in0_n, .io_connector_in1_n);
    ddio_port #(.BASE_KHZ(50000)) i_ddio_port (.*);
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic wr_out(input logic [7:0] a, b);
        @(posedge core_clk);
        {out0_we, out1_we, out0_wdata, out1_wdata} <= {2'b11, a, b};
        @(posedge core_clk);
        {out0_we, out1_we} <= 2'b00;
    endtask : wr_out
    task automatic set_f(input logic [4:0] v);
        @(posedge core_clk);
        {fset_we, fset_wdata} <= {1'b1, v};
        @(posedge core_clk);
        fset_we <= 1'b0;
    endtask : set_f
    task automatic t_out();
        wr_out(8'hA5, 8'h3C);
        wr_out(8'h5A, 8'hC3);
        cyc(2);
        chk("pins", 16'hC35A, {io_connector_out1, io_connector_out0});
        chk("rdata", 16'hC35A, {out1_rdata, out0_rdata});
        cyc(3);
        chk("pins", 16'hC35A, {io_connector_out1, io_connector_out0});
    endtask : t_out
    task automatic t_filter();
        sw_on <= 16'h8001;
        cyc(6);
        chk("bypass", 16'h8001, {in1_rdata, in0_rdata});
        sw_on <= 16'h0000;
        set_f(5'h03);
        cyc(6);
        sw_on <= 16'hFFFF;
        cyc(5);
        sw_on <= 16'h0000;
        cyc(12);
        chk("glitch", 16'h0000, {in1_rdata, in0_rdata});
        sw_on <= 16'hFFFF;
        cyc(6);
        chk("early", 16'h0000, {in1_rdata, in0_rdata});
        cyc(10);
        chk("held", 16'hFFFF, {in1_rdata, in0_rdata});
    endtask : t_filter
    task automatic t_range();
        set_f(5'h15);
        cyc(3);
        chk("fset", 16'h0003, {11'h000, fset_rdata});
        set_f(5'h14);
        cyc(3);
        chk("fset", 16'h0014, {11'h000, fset_rdata});
        clk_en <= 1'b0;
        wr_out(8'hFF, 8'hFF);
        clk_en <= 1'b1;
        cyc(3);
        chk("frozen", 16'hC35A, {io_connector_out1, io_connector_out0});
    endtask : t_range
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        #20000;
        n_errors++;
        results();
    end
    initial begin
        cyc(3);
        reset <= 1'b0;
        chk("out", 16'h0000, {io_connector_out1, io_connector_out0});
        chk("fset", 16'h0000, {11'h000, fset_rdata});
        t_out();
        t_filter();
        t_range();
        results();
    end
endmodule : tb
`default_nettype wire
